// file: hw/wdr_pkg.sv
// Purpose: Shared constants of the watchdog and reset generator.
// Assumes: 32-bit APB, one register per aligned word.
// Notes: Register offsets are byte addresses.
package wdr_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_SYS_TWO = 8'h0c;
   // ----------------------------------------
   // Fields and codes
   // ----------------------------------------
   localparam int ONE_DSEL_LSB = 0;
   localparam int ONE_OSEL_BIT = 2;
   localparam int ONE_RUN_BIT = 3;
   localparam int ONE_SSEL_BIT = 4;
   localparam int SYS_FAST_BIT = 7;
   localparam int SYS_SLOW_BIT = 6;
   localparam logic [7:0] TWO_DISABLE_CODE = 8'hb1;
   localparam logic [7:0] TWO_CLEAR_CODE = 8'h4e;
   localparam logic [1:0] SYS_TWO_RST = 2'h3;
   localparam logic [1:0] DSEL_RST = 2'h0;
   localparam logic [15:0] BOOT_VECTOR = 16'hfffe;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int EXT_LOW_MCYC = 3;
   localparam int GEAR_PER_MCYC = 4;
   localparam int EXT_LOW_CYC = EXT_LOW_MCYC * GEAR_PER_MCYC;
   localparam logic [1:0] MODE_FAST_ONLY = 2'h0;
   localparam logic [1:0] MODE_DUAL = 2'h1;
   localparam logic [1:0] MODE_SLOW = 2'h2;
   typedef enum logic [1:0] {RG_IDLE, RG_DRIVE, RG_EXT} wdr_rg_t;
endpackage

// file: hw/wdr_top.sv
// Purpose: Watchdog timer with protected disable, and the reset generator.
// Assumes: pclk is the fast and gear clock; slow_tick marks one slow period.
// Notes: The shared reset pin is open drain and only ever pulled low.
// Overview of operation
// - Watchdog runs after every reset.
// - Uncleared overflow activates watchdog output.
// - Select one resets, select zero interrupts.
// - Output select writable once; reset default.
// - Counting pauses in stop, warm-up, idle.
// - Four detection times per clock mode; slow mode has two.
// - Run bit three enables watchdog.
// - Disable needs run clear, then code.
// - Disabling clears the whole counter.
// - Interrupt ignores enables, waits for return.
// - Watchdog reset drives pin fixed period.
// - Four reset sources; power-up pulse possible.
// - Reset clears core state, enables watchdog.
// - External low twelve gear clocks recognised.
// - Release on pin high, boot vector.
// - Fetch from RAM/registers causes reset.
// - Both oscillators off forces reset.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module wdr_top
   import wdr_pkg::*;
#(
   parameter int FAST_EXP_MAX = 25,
   parameter int SLOW_EXP_MAX = 17,
   parameter int RST_EXP = 16
)
(
   input wire logic pclk, // Fast clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [1:0] run_mode, // Fast-only, dual or slow run.
   input wire logic slow_tick, // One pulse per slow clock period.
   input wire logic hold_count, // Stop, warm-up or idle in progress.
   input wire logic fetch_trap, // Fetch from RAM or register space.
   input wire logic irq_busy, // Watchdog or software handler active.
   input wire logic irq_ack, // Watchdog interrupt taken.
   input wire logic rst_pin_i, // Reset pin level.
   output logic rst_pin_o, // Reset pin drive value, always low.
   output logic rst_pin_oe, // High while pulling the pin low.
   output logic core_rst, // Clears core state while high.
   output logic boot_start, // Pulse: fetch vector after reset.
   output logic [15:0] boot_vector, // Vector address to fetch.
   output logic wdt_irq, // Watchdog interrupt request.
   output logic fast_osc_on, // Fast oscillator enable.
   output logic slow_osc_on // Slow oscillator enable.
);
   localparam int CW = FAST_EXP_MAX;
   localparam int RW = RST_EXP + 1;
   localparam logic [RW-1:0] RST_CYC = RW'(1) << RST_EXP;

   typedef struct packed {
      wdr_rg_t rg;
      logic en;
      logic run;
      logic osel;
      logic lock;
      logic [1:0] dsel;
      logic ssel;
      logic [1:0] sys;
      logic [CW-1:0] cnt;
      logic [RW-1:0] rcnt;
      logic [3:0] ecnt;
      logic [2:0] cause;
      logic pend;
      logic irq;
      logic boot;
      logic drv;
      logic crst;
      logic fosc;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } wdr_state_t;

   wdr_state_t st_r;
   wdr_state_t st_nxt;
   logic slow_src;
   logic tick;
   logic [4:0] exp;
   logic [CW:0] lim;
   logic ovf;
   logic wr;
   logic int_src;
   logic mapped;
   logic [CW+15:0] cnt_wide;

   // ----------------------------------------
   // Detection time and overflow
   // ----------------------------------------
   always_comb
   begin
      slow_src = (run_mode == MODE_SLOW) || (run_mode == MODE_DUAL && st_r.ssel);
      tick = slow_src ? slow_tick : 1'b1;
      if (run_mode == MODE_SLOW)
         exp = 5'(SLOW_EXP_MAX - 2 * int'(st_r.dsel[0]));
      else if (slow_src)
         exp = 5'(SLOW_EXP_MAX - 2 * int'(st_r.dsel));
      else
         exp = 5'(FAST_EXP_MAX - 2 * int'(st_r.dsel));
      lim = ((CW+1)'(1) << exp) - (CW+1)'(1);
      ovf = st_r.en && !hold_count && tick && ({1'b0, st_r.cnt} == lim);
      wr = psel && penable && st_r.pready && pwrite;
      mapped = paddr == OFS_CTRL_ONE || paddr == OFS_CTRL_TWO
         || paddr == OFS_STATUS || paddr == OFS_SYS_TWO;
      // Padded below so a narrow counter still yields sixteen status bits.
      cnt_wide = {st_r.cnt, 16'h0};
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.boot = 1'b0;
      // Access phase answers one cycle after setup, data registered.
      st_nxt.pready = psel && !penable && !st_r.pready;
      st_nxt.pslverr = psel && !penable && !mapped;
      if (psel && !penable)
      begin
         case (paddr)
            OFS_CTRL_ONE: st_nxt.prdata = {27'h0, st_r.ssel, st_r.run, st_r.osel, st_r.dsel};
            OFS_STATUS: st_nxt.prdata = {cnt_wide[CW+15 -: 16], 8'h0, st_r.cause,
               st_r.lock, st_r.pend, st_r.en, st_r.run, st_r.osel};
            OFS_SYS_TWO: st_nxt.prdata = {24'h0, st_r.sys, 6'h0};
            default: st_nxt.prdata = 32'h0;
         endcase
      end
      if (wr && paddr == OFS_CTRL_TWO && pwdata[7:0] == TWO_CLEAR_CODE)
         st_nxt.cnt = '0;
      else if (ovf)
         st_nxt.cnt = '0;
      else if (st_r.en && !hold_count && tick)
         st_nxt.cnt = st_r.cnt + CW'(1);
      if (wr && paddr == OFS_CTRL_ONE)
      begin
         st_nxt.dsel = pwdata[ONE_DSEL_LSB +: 2];
         st_nxt.ssel = pwdata[ONE_SSEL_BIT];
         st_nxt.run = pwdata[ONE_RUN_BIT];
         if (pwdata[ONE_RUN_BIT])
            st_nxt.en = 1'b1;
         if (!st_r.lock)
         begin
            st_nxt.osel = pwdata[ONE_OSEL_BIT];
            st_nxt.lock = 1'b1;
         end
      end
      if (wr && paddr == OFS_CTRL_TWO && pwdata[7:0] == TWO_DISABLE_CODE && !st_r.run)
      begin
         st_nxt.en = 1'b0;
         st_nxt.cnt = '0;
      end
      if (wr && paddr == OFS_SYS_TWO)
         st_nxt.sys = {pwdata[SYS_FAST_BIT], pwdata[SYS_SLOW_BIT]};
      if (ovf && !st_r.osel)
         st_nxt.pend = 1'b1;
      else if (irq_ack)
         st_nxt.pend = 1'b0;
      st_nxt.irq = st_nxt.pend && !irq_busy;
      int_src = (ovf && st_r.osel) || fetch_trap || st_r.sys == 2'h0;
      case (st_r.rg)
         RG_IDLE:
         begin
            st_nxt.ecnt = rst_pin_i ? 4'h0 : st_r.ecnt + 4'h1;
            if (int_src)
            begin
               st_nxt.rg = RG_DRIVE;
               st_nxt.rcnt = '0;
               st_nxt.cause = {fetch_trap, st_r.sys == 2'h0, ovf};
            end
            else if (!rst_pin_i && st_r.ecnt == 4'(EXT_LOW_CYC - 1))
            begin
               st_nxt.rg = RG_EXT;
               st_nxt.cause = 3'h0;
            end
         end
         RG_DRIVE:
         begin
            st_nxt.rcnt = st_r.rcnt + RW'(1);
            if (st_r.rcnt == RST_CYC - RW'(1))
            begin
               st_nxt.rg = RG_EXT;
               st_nxt.ecnt = 4'h0;
            end
         end
         RG_EXT:
         begin
            if (rst_pin_i)
            begin
               st_nxt.rg = RG_IDLE;
               st_nxt.boot = 1'b1;
               st_nxt.ecnt = 4'h0;
            end
         end
         default: st_nxt.rg = RG_IDLE;
      endcase
      if (st_r.rg != RG_IDLE)
      begin
         st_nxt.en = 1'b1;
         st_nxt.run = 1'b1;
         st_nxt.osel = 1'b1;
         st_nxt.lock = 1'b0;
         st_nxt.dsel = DSEL_RST;
         st_nxt.ssel = 1'b0;
         st_nxt.sys = SYS_TWO_RST;
         st_nxt.cnt = '0;
         st_nxt.pend = 1'b0;
         st_nxt.irq = 1'b0;
      end
      st_nxt.drv = st_nxt.rg == RG_DRIVE;
      st_nxt.crst = st_nxt.rg != RG_IDLE;
      st_nxt.fosc = st_nxt.sys[1] || st_nxt.rg == RG_DRIVE;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
         // Internal sources start uninitialised, so power-up gives one pulse.
         st_r.rg <= RG_DRIVE;
         st_r.en <= 1'b1;
         st_r.run <= 1'b1;
         st_r.osel <= 1'b1;
         st_r.sys <= SYS_TWO_RST;
         st_r.drv <= 1'b1;
         st_r.crst <= 1'b1;
         st_r.fosc <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe = st_r.drv;
   assign core_rst = st_r.crst;
   assign boot_start = st_r.boot;
   assign boot_vector = BOOT_VECTOR;
   assign wdt_irq = st_r.irq;
   assign fast_osc_on = st_r.fosc;
   assign slow_osc_on = st_r.sys[0];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_overflow_reset: assert property (ovf && st_r.osel |=> st_r.rg == RG_DRIVE)
      else $error("overflow with reset select did not drive reset");
   a_overflow_irq: assert property (ovf && !st_r.osel && st_r.rg == RG_IDLE |=> st_r.pend)
      else $error("overflow with interrupt select left no pending request");
   a_clear_wins: assert property (wr && paddr == OFS_CTRL_TWO
      && pwdata[7:0] == TWO_CLEAR_CODE && st_r.rg == RG_IDLE |=> st_r.cnt == '0)
      else $error("clear did not zero the counter");
   a_disable_order: assert property (wr && paddr == OFS_CTRL_TWO
      && pwdata[7:0] == TWO_DISABLE_CODE && st_r.run && st_r.en |=> st_r.en)
      else $error("disable code accepted while run bit set");
   a_hold_count: assert property (hold_count && st_r.rg == RG_IDLE && !wr
      |=> $stable(st_r.cnt))
      else $error("counter moved during low-power hold");
   a_reset_enables: assert property (st_r.rg != RG_IDLE |=> st_r.en && st_r.osel && !st_r.lock)
      else $error("watchdog not enabled by reset");
   a_trap_reset: assert property (fetch_trap && st_r.rg == RG_IDLE
      |=> rst_pin_oe [*8])
      else $error("fetch trap did not pull reset pin low");
   // The low-time counter stands in for a long repetition of the pin level.
   a_ext_reset: assert property (st_r.rg == RG_IDLE && !rst_pin_i && !int_src
      && st_r.ecnt == 4'(EXT_LOW_CYC - 1) |=> core_rst)
      else $error("long external low not recognised");
   a_lock_once: assert property (st_r.lock && st_r.rg == RG_IDLE |=> $stable(st_r.osel))
      else $error("output select changed after lock");
   a_irq_wait: assert property (irq_busy |=> !wdt_irq)
      else $error("watchdog interrupt raised during handler");

   c_wdt_reset: cover property (ovf && st_r.osel);
   c_wdt_irq: cover property (wdt_irq);
   c_disable: cover property (st_r.en ##1 !st_r.en);
   c_boot: cover property (boot_start);
endmodule // wdr_top
`default_nettype wire

// file: bench/wdr_ext_rst.sv
// Purpose: Outside circuit sharing the open-drain reset line.
// Assumes: The line has a pull-up, so it reads high when nobody pulls.
// Notes: Any pulse length can be ordered, so too-short pulses are possible.
`timescale 1ns/1ps
`default_nettype none
module wdr_ext_rst (
   input wire logic pclk, // Clock.
   input wire logic start, // Start a low pulse.
   input wire logic [7:0] len, // Pulse length in cycles.
   input wire logic dev_oe, // Device pulls the line low.
   output logic pin // Resolved line level.
);
   logic [7:0] left_r = 8'h00;
   always @(posedge pclk)
   begin
      if (start)
         left_r <= len;
      else if (left_r != 8'h00)
         left_r <= left_r - 8'h01;
   end
   assign pin = ~(dev_oe | (left_r != 8'h00));
endmodule // wdr_ext_rst
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench for the watchdog and reset generator.
// Assumes: Exponents cut to 8, 6 and 5; slow_tick every fourth clock.
// Notes: Output choice locks once, so the reset output is tested first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wdr_pkg::*;
   typedef struct packed {logic [1:0] mode; logic [7:0] ctrl; logic [15:0] cyc;} wdr_row_t;
   localparam int RP = 5;
   localparam wdr_row_t ROWS [8] = '{'{2'h0, 8'h08, 16'h0100}, '{2'h0, 8'h09, 16'h0040},
      '{2'h0, 8'h0a, 16'h0010}, '{2'h0, 8'h0b, 16'h0004}, '{2'h1, 8'h09, 16'h0040},
      '{2'h1, 8'h1a, 16'h0010}, '{2'h2, 8'h09, 16'h0040}, '{2'h2, 8'h08, 16'h0100}};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ext_len = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, rst_pin, rst_pin_oe, core_rst, boot_start, wdt_irq, rst_pin_drv;
   logic fast_osc_on, slow_osc_on, slow_tick = 1'b0, hold_count = 1'b0, fetch_trap = 1'b0;
   logic irq_busy = 1'b0, irq_ack = 1'b0, ext_go = 1'b0;
   logic [1:0] run_mode = 2'h0, tdiv = 2'h0;
   logic [15:0] boot_vector;
   int n_mismatch = 0, n_tests = 0, n, k;
   always #2 pclk = ~pclk;
   always @(posedge pclk)
   begin
      tdiv <= tdiv + 2'h1;
      slow_tick <= (tdiv == 2'h3);
   end
   wdr_top #(.FAST_EXP_MAX(8), .SLOW_EXP_MAX(6), .RST_EXP(RP)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_mode(run_mode), .slow_tick(slow_tick), .hold_count(hold_count),
      .fetch_trap(fetch_trap), .irq_busy(irq_busy), .irq_ack(irq_ack), .rst_pin_i(rst_pin),
      .rst_pin_o(rst_pin_drv), .rst_pin_oe(rst_pin_oe), .core_rst(core_rst),
      .boot_start(boot_start),
      .boot_vector(boot_vector), .wdt_irq(wdt_irq), .fast_osc_on(fast_osc_on),
      .slow_osc_on(slow_osc_on));
   wdr_ext_rst ext_side (.pclk(pclk), .start(ext_go), .len(ext_len), .dev_oe(rst_pin_oe),
      .pin(rst_pin));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("Tests %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic near(input int a, input int b);
      return a >= b - 6 && a <= b + 6;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ack();
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
   endtask
   task automatic clr_ack();
      apb(1'b1, OFS_CTRL_TWO, {24'h0, TWO_CLEAR_CODE});
      ack();
   endtask
   task automatic cnt(input int lim);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (wdt_irq !== 1'b1 && n < lim);
   endtask
   task automatic meas(input int lim);
      k = 0;
      n = 0;
      while (rst_pin_oe !== 1'b1 && k < lim)
      begin
         @(posedge pclk);
         k++;
      end
      chk(fast_osc_on, 1'b1);
      chk(rst_pin_drv, 1'b0);
      while (rst_pin_oe === 1'b1 && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic wait_boot();
      k = 0;
      while (boot_start !== 1'b1 && k < 3000)
      begin
         @(posedge pclk);
         k++;
      end
      chk(boot_vector, 16'hfffe);
      @(posedge pclk);
      chk(core_rst, 1'b0);
   endtask
   task automatic ext(input logic [7:0] len);
      ext_len <= len;
      ext_go <= 1'b1;
      @(posedge pclk);
      ext_go <= 1'b0;
      k = 0;
      n = 0;
      repeat (30)
      begin
         @(posedge pclk);
         k += (core_rst === 1'b1);
         n += (boot_start === 1'b1);
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      chk({rst_pin_oe, core_rst}, 2'b11);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      meas(200);
      chk(near(n, 1 << RP), 1'b1);
      wait_boot();
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      chk(rd[3:2], 2'b11);
      meas(400);
      chk(n, 1 << RP);
      wait_boot();
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      chk(rd[3:2], 2'b11);
      for (int i = 0; i < 8; i++)
      begin
         run_mode <= ROWS[i].mode;
         hold_count <= 1'b1;
         apb(1'b1, OFS_CTRL_ONE, {24'h0, ROWS[i].ctrl});
         clr_ack();
         hold_count <= 1'b0;
         cnt(600);
         chk(near(n, ROWS[i].cyc), 1'b1);
      end
      apb(1'b1, OFS_CTRL_ONE, 32'h0000000c);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[0], 1'b0);
      chk(er, 1'b0);
      run_mode <= 2'h0;
      hold_count <= 1'b1;
      apb(1'b1, OFS_CTRL_ONE, 32'h0000000a);
      apb(1'b1, OFS_CTRL_TWO, {24'h0, TWO_DISABLE_CODE});
      clr_ack();
      hold_count <= 1'b0;
      cnt(100);
      chk(near(n, 16), 1'b1);
      repeat (10) @(posedge pclk);
      hold_count <= 1'b1;
      apb(1'b1, OFS_CTRL_ONE, 32'h00000002);
      apb(1'b1, OFS_CTRL_TWO, {24'h0, TWO_DISABLE_CODE});
      ack();
      hold_count <= 1'b0;
      cnt(300);
      chk(n, 300);
      apb(1'b1, OFS_CTRL_ONE, 32'h0000000a);
      cnt(100);
      chk(near(n, 16), 1'b1);
      irq_busy <= 1'b1;
      @(posedge pclk);
      cnt(40);
      chk(n, 40);
      irq_busy <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(wdt_irq, 1'b1);
      hold_count <= 1'b1;
      ack();
      @(posedge pclk);
      chk(wdt_irq, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      hold_count <= 1'b0;
      fetch_trap <= 1'b1;
      @(posedge pclk);
      fetch_trap <= 1'b0;
      meas(10);
      chk(n, 1 << RP);
      wait_boot();
      apb(1'b1, OFS_SYS_TWO, 32'h0);
      meas(10);
      chk(n, 1 << RP);
      wait_boot();
      chk({fast_osc_on, slow_osc_on}, 2'b11);
      ext(8'h0a);
      chk(k, 0);
      ext(8'h0e);
      chk(k > 0, 1'b1);
      chk(n, 1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      meas(10);
      chk(near(n, 1 << RP), 1'b1);
      wait_boot();
      report_and_stop();
   end
   initial
   begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
